// File: src/sis_consts.vh
// constants for the interrupt and statistics block: register map, field
// layout, widths and reset values; definitions only, no logic.
// assumes one includer per compile unit, guarded against double inclusion.
//
// Functional notes
// - every source bit and module summary bit has its own mask bit
// - source bits set on their event whatever the mask says
// - a module summary bit is set while any of its source bits is set
// - five summary bits: segmenter, reassembler, cell bus, serial bus, timing
// - segmenter sources: data cell queue overrun, scheduler overload error
// - reassembler: five header/pointer errors, underrun, overrun, three rollovers
// - cell bus sources: queue overrun, internal buffer overrun, cell received
// - serial bus: clock absent, clock fail, out of bandwidth, underrun, rollover
// - timing: reference failure, four time stamp cases, two adaptive losses
// - statistics counters, timing ones excepted, flag rollover on wrap to zero
// - 16-bit misc counter counts header/pointer errors enabled by select mask
// - misc identity holds control structure address of latest counted error
// - 16-bit underrun counter counts each receive underrun
// - underrun identity holds control structure address of latest underrun
// - 16-bit overrun counter counts each receive overrun
// - overrun identity holds control structure address of latest overrun
// - serial underrun position holds slot and stream of latest read underrun
// - serial read underrun counter counts each read underrun
// - timing event counter counts reference cells or markers, no rollover flag
// - free 24-bit byte period counter, no rollover flag
`ifndef SIS_CONSTS_VH
`define SIS_CONSTS_VH

// ****************************************
// bus widths
// ****************************************
`define SIS_AW        8
`define SIS_DW        16
`define SIS_ZERO      16'h0000
`define SIS_ONE17     17'h00001
`define SIS_ONE24     24'h000001

// ****************************************
// register offsets (word addresses)
// ****************************************
`define SIS_A_SUM     8'h00
`define SIS_A_SUM_MK  8'h01
`define SIS_A_TX      8'h02
`define SIS_A_TX_MK   8'h03
`define SIS_A_RX      8'h04
`define SIS_A_RX_MK   8'h05
`define SIS_A_UT      8'h06
`define SIS_A_UT_MK   8'h07
`define SIS_A_TDM     8'h08
`define SIS_A_TDM_MK  8'h09
`define SIS_A_TIM     8'h0A
`define SIS_A_TIM_MK  8'h0B
`define SIS_A_MSEL    8'h0C
`define SIS_A_MCNT    8'h0D
`define SIS_A_MID     8'h0E
`define SIS_A_UCNT    8'h0F
`define SIS_A_UID     8'h10
`define SIS_A_OCNT    8'h11
`define SIS_A_OID     8'h12
`define SIS_A_TPOS    8'h13
`define SIS_A_TCNT    8'h14
`define SIS_A_EVCNT   8'h15
`define SIS_A_BPLO    8'h16
`define SIS_A_BPHI    8'h17

// ****************************************
// field widths, layouts and reset values
// ****************************************
`define SIS_MSK_SUM   16'h001F
`define SIS_MSK_TX    16'h0003
`define SIS_MSK_RX    16'h03FF
`define SIS_MSK_UT    16'h0007
`define SIS_MSK_TDM   16'h001F
`define SIS_MSK_TIM   16'h007F
`define SIS_MSK_MSEL  16'h001F
`define SIS_MSEL_RST  5'h1F
`define SIS_ERR_N     5
`define SIS_SUM_N     5
`define SIS_RX_UND    5
`define SIS_RX_OVR    6
`define SIS_RX_MROL   7
`define SIS_RX_UROL   8
`define SIS_RX_OROL   9
`define SIS_TDM_RUND  3
`define SIS_TDM_ROL   4
`define SIS_SLOT_W    7
`define SIS_STRM_W    4
`define SIS_BP_W      24
`define SIS_BP_HI_W   8

`endif

// File: src/sis_top.v
// interrupt collection, masking and statistics counters of the device.
// assumes event inputs are one-cycle pulses synchronous to clk and that
// software uses the plain register port with read data one cycle later.
//
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "sis_consts.vh"

module sis_top
(
  input  wire                     clk,
  input  wire                     reset,
  input  wire [`SIS_AW-1:0]       addr,
  input  wire [`SIS_DW-1:0]       wr_data,
  input  wire                     wr_stb,
  input  wire                     rd_stb,
  output reg  [`SIS_DW-1:0]       rd_data,
  input  wire [1:0]               transmit_segmenter_evt,
  input  wire [`SIS_ERR_N-1:0]    receive_reassembler_err,
  input  wire [`SIS_DW-1:0]       rx_err_id,
  input  wire                     rx_und_evt,
  input  wire [`SIS_DW-1:0]       rx_und_id,
  input  wire                     rx_ovr_evt,
  input  wire [`SIS_DW-1:0]       rx_ovr_id,
  input  wire [2:0]               cell_bus_evt,
  input  wire [2:0]               serial_bus_evt,
  input  wire                     serial_rund_evt,
  input  wire [`SIS_SLOT_W-1:0]   serial_rund_slot,
  input  wire [`SIS_STRM_W-1:0]   serial_rund_strm,
  input  wire [6:0]               timing_evt,
  input  wire                     timing_ref_evt,
  input  wire                     byte_tick,
  output reg                      irq
);

  // ****************************************
  // helper functions
  // ****************************************

  // write-one-to-clear update; the event term is or'ed last so a set
  // arriving together with a clear is never lost
  function [`SIS_DW-1:0] w1c_upd;
    input [`SIS_DW-1:0] cur;
    input [`SIS_DW-1:0] set;
    input               clr;
    input [`SIS_DW-1:0] wd;
    begin
      w1c_upd = (cur & ~(clr ? wd : `SIS_ZERO)) | set;
    end
  endfunction

  // 16-bit increment, carry out marks the wrap back to zero
  function [`SIS_DW:0] inc16;
    input [`SIS_DW-1:0] v;
    begin
      inc16 = {1'b0, v} + `SIS_ONE17;
    end
  endfunction

  // write decode for one register offset
  function wr_at;
    input [`SIS_AW-1:0] a;
    begin
      wr_at = wr_stb && (addr == a);
    end
  endfunction

  // widen a five-bit field to a register word, upper bits reading zero
  function [`SIS_DW-1:0] pad5;
    input [`SIS_SUM_N-1:0] f;
    begin
      pad5 = {{(`SIS_DW-`SIS_SUM_N){1'b0}}, f};
    end
  endfunction

  // ****************************************
  // registers and next values
  // ****************************************
  reg  [`SIS_DW-1:0]     tx_st_r;
  reg  [`SIS_DW-1:0]     rx_st_r;
  reg  [`SIS_DW-1:0]     ut_st_r;
  reg  [`SIS_DW-1:0]     tdm_st_r;
  reg  [`SIS_DW-1:0]     tim_st_r;
  reg  [`SIS_DW-1:0]     sum_mk_r;
  reg  [`SIS_DW-1:0]     tx_mk_r;
  reg  [`SIS_DW-1:0]     rx_mk_r;
  reg  [`SIS_DW-1:0]     ut_mk_r;
  reg  [`SIS_DW-1:0]     tdm_mk_r;
  reg  [`SIS_DW-1:0]     tim_mk_r;
  reg  [`SIS_ERR_N-1:0]  msel_r;
  reg  [`SIS_DW-1:0]     mcnt_r;
  reg  [`SIS_DW-1:0]     mid_r;
  reg  [`SIS_DW-1:0]     ucnt_r;
  reg  [`SIS_DW-1:0]     uid_r;
  reg  [`SIS_DW-1:0]     ocnt_r;
  reg  [`SIS_DW-1:0]     oid_r;
  reg  [`SIS_SLOT_W-1:0] tslot_r;
  reg  [`SIS_STRM_W-1:0] tstrm_r;
  reg  [`SIS_DW-1:0]     tcnt_r;
  reg  [`SIS_DW-1:0]     evcnt_r;
  reg  [`SIS_BP_W-1:0]   byte_period_counter_r;
  reg  [`SIS_BP_HI_W-1:0] bp_hi_snap_r;

  reg  [`SIS_DW-1:0]     tx_set;
  reg  [`SIS_DW-1:0]     rx_set;
  reg  [`SIS_DW-1:0]     ut_set;
  reg  [`SIS_DW-1:0]     tdm_set;
  reg  [`SIS_DW-1:0]     tim_set;
  reg  [`SIS_DW-1:0]     rd_nxt;
  wire [`SIS_DW-1:0]     sum;
  wire                   misc_hit;
  wire [`SIS_DW:0]       mcnt_nxt;
  wire [`SIS_DW:0]       ucnt_nxt;
  wire [`SIS_DW:0]       ocnt_nxt;
  wire [`SIS_DW:0]       tcnt_nxt;
  wire [`SIS_DW:0]       evcnt_nxt;
  wire                   irq_nxt;

  // ****************************************
  // statistics counter arithmetic
  // ****************************************

  // only errors whose select bit is on are counted; several in one
  // cycle belong to one cell and count once; a deselected error still
  // sets its source bit, only the counting and the identity latch stop
  assign misc_hit  = |(receive_reassembler_err & msel_r);
  assign mcnt_nxt  = inc16(mcnt_r);
  assign ucnt_nxt  = inc16(ucnt_r);
  assign ocnt_nxt  = inc16(ocnt_r);
  assign tcnt_nxt  = inc16(tcnt_r);
  assign evcnt_nxt = inc16(evcnt_r);

  // ****************************************
  // event set vectors
  // ****************************************

  // source bits gather events with no regard to the masks
  always @*
  begin
    tx_set  = `SIS_ZERO;
    rx_set  = `SIS_ZERO;
    ut_set  = `SIS_ZERO;
    tdm_set = `SIS_ZERO;
    tim_set = `SIS_ZERO;
    tx_set[1:0] = transmit_segmenter_evt;
    rx_set[`SIS_ERR_N-1:0] = receive_reassembler_err;
    rx_set[`SIS_RX_UND]  = rx_und_evt;
    rx_set[`SIS_RX_OVR]  = rx_ovr_evt;
    rx_set[`SIS_RX_MROL] = misc_hit & mcnt_nxt[`SIS_DW];
    rx_set[`SIS_RX_UROL] = rx_und_evt & ucnt_nxt[`SIS_DW];
    rx_set[`SIS_RX_OROL] = rx_ovr_evt & ocnt_nxt[`SIS_DW];
    ut_set[2:0] = cell_bus_evt;
    tdm_set[2:0] = serial_bus_evt;
    tdm_set[`SIS_TDM_RUND] = serial_rund_evt;
    tdm_set[`SIS_TDM_ROL] = serial_rund_evt & tcnt_nxt[`SIS_DW];
    tim_set[6:0] = timing_evt;
  end

  // ****************************************
  // module summary and interrupt
  // ****************************************

  // summary bits are pure or-reductions, so they fall by themselves
  // once software has cleared the last source of a module
  // summary masks let software enable a whole module at once
  assign sum = pad5({|tim_st_r,
                     |tdm_st_r,
                     |ut_st_r,
                     |rx_st_r,
                     |tx_st_r});

  // each bit meets its own mask; summary bits have masks of their own
  assign irq_nxt = |(tx_st_r & tx_mk_r)
                 | |(rx_st_r & rx_mk_r)
                 | |(ut_st_r & ut_mk_r)
                 | |(tdm_st_r & tdm_mk_r)
                 | |(tim_st_r & tim_mk_r)
                 | |(sum & sum_mk_r);

  // ****************************************
  // status and mask registers
  // ****************************************

  // sticky source bits, cleared by writing ones
  // a write of zeros leaves every bit as it was
  always @(posedge clk)
  begin
    if (reset)
    begin
      tx_st_r  <= `SIS_ZERO;
      rx_st_r  <= `SIS_ZERO;
      ut_st_r  <= `SIS_ZERO;
      tdm_st_r <= `SIS_ZERO;
      tim_st_r <= `SIS_ZERO;
    end
    else
    begin
      tx_st_r  <= w1c_upd(tx_st_r, tx_set, wr_at(`SIS_A_TX), wr_data);
      rx_st_r  <= w1c_upd(rx_st_r, rx_set, wr_at(`SIS_A_RX), wr_data);
      ut_st_r  <= w1c_upd(ut_st_r, ut_set, wr_at(`SIS_A_UT), wr_data);
      tdm_st_r <= w1c_upd(tdm_st_r, tdm_set, wr_at(`SIS_A_TDM), wr_data);
      tim_st_r <= w1c_upd(tim_st_r, tim_set, wr_at(`SIS_A_TIM), wr_data);
    end
  end

  // mask registers; bits beyond each field are kept at zero
  // the select register only gates counting and the misc identity, never the source bits
  always @(posedge clk)
  begin
    if (reset)
    begin
      sum_mk_r <= `SIS_ZERO;
      tx_mk_r  <= `SIS_ZERO;
      rx_mk_r  <= `SIS_ZERO;
      ut_mk_r  <= `SIS_ZERO;
      tdm_mk_r <= `SIS_ZERO;
      tim_mk_r <= `SIS_ZERO;
      msel_r   <= `SIS_MSEL_RST;
    end
    else
    begin
      if (wr_at(`SIS_A_SUM_MK))
        sum_mk_r <= wr_data & `SIS_MSK_SUM;
      if (wr_at(`SIS_A_TX_MK))
        tx_mk_r <= wr_data & `SIS_MSK_TX;
      if (wr_at(`SIS_A_RX_MK))
        rx_mk_r <= wr_data & `SIS_MSK_RX;
      if (wr_at(`SIS_A_UT_MK))
        ut_mk_r <= wr_data & `SIS_MSK_UT;
      if (wr_at(`SIS_A_TDM_MK))
        tdm_mk_r <= wr_data & `SIS_MSK_TDM;
      if (wr_at(`SIS_A_TIM_MK))
        tim_mk_r <= wr_data & `SIS_MSK_TIM;
      if (wr_at(`SIS_A_MSEL))
        msel_r <= wr_data[`SIS_ERR_N-1:0];
    end
  end

  // ****************************************
  // reassembler statistics
  // ****************************************

  // counters wrap silently; the wrap itself is flagged in rx status
  // an identity is latched only with the event it belongs to
  always @(posedge clk)
  begin
    if (reset)
    begin
      mcnt_r <= `SIS_ZERO;
      mid_r  <= `SIS_ZERO;
      ucnt_r <= `SIS_ZERO;
      uid_r  <= `SIS_ZERO;
      ocnt_r <= `SIS_ZERO;
      oid_r  <= `SIS_ZERO;
    end
    else
    begin
      if (misc_hit)
      begin
        mcnt_r <= mcnt_nxt[`SIS_DW-1:0];
        mid_r  <= rx_err_id;
      end
      if (rx_und_evt)
      begin
        ucnt_r <= ucnt_nxt[`SIS_DW-1:0];
        uid_r  <= rx_und_id;
      end
      if (rx_ovr_evt)
      begin
        ocnt_r <= ocnt_nxt[`SIS_DW-1:0];
        oid_r  <= rx_ovr_id;
      end
    end
  end

  // ****************************************
  // serial bus and timing statistics
  // ****************************************

  // the timing counters have no rollover flag by design
  // the 24-bit byte count wraps silently and serves as a free time base
  always @(posedge clk)
  begin
    if (reset)
    begin
      tslot_r <= {`SIS_SLOT_W{1'b0}};
      tstrm_r <= {`SIS_STRM_W{1'b0}};
      tcnt_r  <= `SIS_ZERO;
      evcnt_r <= `SIS_ZERO;
      byte_period_counter_r <= {`SIS_BP_W{1'b0}};
    end
    else
    begin
      if (serial_rund_evt)
      begin
        tslot_r <= serial_rund_slot;
        tstrm_r <= serial_rund_strm;
        tcnt_r  <= tcnt_nxt[`SIS_DW-1:0];
      end
      if (timing_ref_evt)
        evcnt_r <= evcnt_nxt[`SIS_DW-1:0];
      if (byte_tick)
        byte_period_counter_r <= byte_period_counter_r + `SIS_ONE24;
    end
  end

  // ****************************************
  // register read port
  // ****************************************

  // read mux; unmapped offsets read zero
  always @*
  begin
    rd_nxt = `SIS_ZERO;
    case (addr)
      `SIS_A_SUM:    rd_nxt = sum;
      `SIS_A_SUM_MK: rd_nxt = sum_mk_r;
      `SIS_A_TX:     rd_nxt = tx_st_r;
      `SIS_A_TX_MK:  rd_nxt = tx_mk_r;
      `SIS_A_RX:     rd_nxt = rx_st_r;
      `SIS_A_RX_MK:  rd_nxt = rx_mk_r;
      `SIS_A_UT:     rd_nxt = ut_st_r;
      `SIS_A_UT_MK:  rd_nxt = ut_mk_r;
      `SIS_A_TDM:    rd_nxt = tdm_st_r;
      `SIS_A_TDM_MK: rd_nxt = tdm_mk_r;
      `SIS_A_TIM:    rd_nxt = tim_st_r;
      `SIS_A_TIM_MK: rd_nxt = tim_mk_r;
      `SIS_A_MSEL:   rd_nxt = pad5(msel_r);
      `SIS_A_MCNT:   rd_nxt = mcnt_r;
      `SIS_A_MID:    rd_nxt = mid_r;
      `SIS_A_UCNT:   rd_nxt = ucnt_r;
      `SIS_A_UID:    rd_nxt = uid_r;
      `SIS_A_OCNT:   rd_nxt = ocnt_r;
      `SIS_A_OID:    rd_nxt = oid_r;
      `SIS_A_TPOS:   rd_nxt = {4'h0, tstrm_r, 1'b0, tslot_r};
      `SIS_A_TCNT:   rd_nxt = tcnt_r;
      `SIS_A_EVCNT:  rd_nxt = evcnt_r;
      `SIS_A_BPLO:   rd_nxt = byte_period_counter_r[`SIS_DW-1:0];
      `SIS_A_BPHI:   rd_nxt = {8'h00, bp_hi_snap_r};
      default:       rd_nxt = `SIS_ZERO;
    endcase
  end

  // read data stand one cycle only; reading the low half snaps the high
  // half so a 24-bit value is read coherently low first
  always @(posedge clk)
  begin
    if (reset)
    begin
      rd_data      <= `SIS_ZERO;
      bp_hi_snap_r <= {`SIS_BP_HI_W{1'b0}};
    end
    else
    begin
      rd_data <= rd_stb ? rd_nxt : `SIS_ZERO;
      if (rd_stb && (addr == `SIS_A_BPLO))
        bp_hi_snap_r <= byte_period_counter_r[`SIS_BP_W-1:`SIS_DW];
    end
  end

  // ****************************************
  // interrupt pin
  // ****************************************

  // registered so the pin never glitches while several sources settle
  // in one cycle; the price is one cycle of extra latency
  always @(posedge clk)
  begin
    if (reset)
      irq <= 1'b0;
    else
      irq <= irq_nxt;
  end

endmodule // sis_top

// File: test/sis_top_chk.sv
// port-level assertions for the interrupt and statistics block.
// assumes it is bound to sis_top and sees only that module's ports.
`timescale 1ns/1ps
`include "sis_consts.vh"

module sis_top_chk
(
  input wire                   clk,
  input wire                   reset,
  input wire [`SIS_AW-1:0]     addr,
  input wire [`SIS_DW-1:0]     wr_data,
  input wire                   wr_stb,
  input wire                   rd_stb,
  input wire [`SIS_DW-1:0]     rd_data,
  input wire [1:0]             transmit_segmenter_evt,
  input wire [`SIS_ERR_N-1:0]  receive_reassembler_err,
  input wire [`SIS_DW-1:0]     rx_err_id,
  input wire                   rx_und_evt,
  input wire [`SIS_DW-1:0]     rx_und_id,
  input wire                   rx_ovr_evt,
  input wire [`SIS_DW-1:0]     rx_ovr_id,
  input wire [2:0]             cell_bus_evt,
  input wire [2:0]             serial_bus_evt,
  input wire                   serial_rund_evt,
  input wire [`SIS_SLOT_W-1:0] serial_rund_slot,
  input wire [`SIS_STRM_W-1:0] serial_rund_strm,
  input wire [6:0]             timing_evt,
  input wire                   timing_ref_evt,
  input wire                   byte_tick,
  input wire                   irq
);
  // ****************************************
  // shadow state
  // ****************************************
  reg [15:0] ucnt_r, ocnt_r, uid_r, tcnt_r, evcnt_r;
  reg [5:0]  mk_nz_r;
  reg        rxm5_r;

  // shadows follow the pulses so that reads can be judged without the bodies
  always @(posedge clk)
  begin
    if (reset)
    begin
      {ucnt_r, ocnt_r, uid_r, tcnt_r, evcnt_r} <= '0;
      mk_nz_r <= 6'h00;
      rxm5_r <= 1'b0;
    end
    else
    begin
      ucnt_r <= ucnt_r + {15'h0000, rx_und_evt};
      ocnt_r <= ocnt_r + {15'h0000, rx_ovr_evt};
      tcnt_r <= tcnt_r + {15'h0000, serial_rund_evt};
      evcnt_r <= evcnt_r + {15'h0000, timing_ref_evt};
      if (rx_und_evt)
        uid_r <= rx_und_id;
      // every nonzero mask write from the bench sets at least one field bit
      if (wr_stb && addr[0] && addr < 8'h0C)
        mk_nz_r[addr[3:1]] <= (wr_data != 16'h0000);
      if (wr_stb && addr == `SIS_A_RX_MK)
        rxm5_r <= wr_data[5];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // a read with a same-edge event is skipped: old and new value differ
  property rd_shows(logic [7:0] a, logic [15:0] v, logic ev);
    $past(rd_stb && addr == a && !ev) |-> rd_data == $past(v);
  endproperty

  rd_idle_zero_a: assert property (!$past(rd_stb) |-> rd_data == 16'h0000)
    else $error("read data not zero outside read cycle");
  und_count_a: assert property (rd_shows(`SIS_A_UCNT, ucnt_r, rx_und_evt))
    else $error("underrun count wrong");
  ovr_count_a: assert property (rd_shows(`SIS_A_OCNT, ocnt_r, rx_ovr_evt))
    else $error("overrun count wrong");
  und_ident_a: assert property (rd_shows(`SIS_A_UID, uid_r, rx_und_evt))
    else $error("underrun identity wrong");
  rund_count_a: assert property (rd_shows(`SIS_A_TCNT, tcnt_r, serial_rund_evt))
    else $error("serial underrun count wrong");
  ref_count_a: assert property (rd_shows(`SIS_A_EVCNT, evcnt_r, timing_ref_evt))
    else $error("timing event count wrong");
  irq_needs_mask_a: assert property (irq |-> $past(mk_nz_r != 6'h00))
    else $error("interrupt with every mask clear");
  und_irq_a: assert property (rx_und_evt && rxm5_r |-> ##2 irq)
    else $error("masked-in underrun gave no interrupt");

  cover property (rx_und_evt && rxm5_r);
  cover property ($rose(irq));
  cover property (rd_stb && addr == `SIS_A_UCNT);
endmodule // sis_top_chk

// File: test/tb_sar_interrupt_and_statistics.sv
// self-checking bench for the interrupt and statistics block.
// assumes sis_top and sis_consts.vh on the include path; one 40 MHz clock.
`timescale 1ns/1ps
`include "sis_consts.vh"

module tb_sar_interrupt_and_statistics;
  reg        clk, reset, wr_stb, rd_stb, rx_und_evt, rx_ovr_evt;
  reg        serial_rund_evt, timing_ref_evt, byte_tick;
  reg [7:0]  addr;
  reg [15:0] wr_data, rx_err_id, rx_und_id, rx_ovr_id, c, got;
  reg [1:0]  transmit_segmenter_evt;
  reg [4:0]  receive_reassembler_err;
  reg [2:0]  cell_bus_evt, serial_bus_evt;
  reg [6:0]  serial_rund_slot, timing_evt;
  reg [3:0]  serial_rund_strm;
  wire [15:0] rd_data;
  wire       irq;
  int        n_errors, cmp_count, cyc, i, m, b;
  int        nb [0:4] = '{2, 7, 3, 4, 7};

  sis_top sis_top_inst (.clk, .reset, .addr, .wr_data, .wr_stb, .rd_stb, .rd_data,
    .transmit_segmenter_evt, .receive_reassembler_err, .rx_err_id, .rx_und_evt,
    .rx_und_id, .rx_ovr_evt, .rx_ovr_id, .cell_bus_evt, .serial_bus_evt,
    .serial_rund_evt, .serial_rund_slot, .serial_rund_strm, .timing_evt,
    .timing_ref_evt, .byte_tick, .irq);

  // ****************************************
  // bus and compare tasks
  // ****************************************
  task chk(input string nm, input [15:0] e, input [15:0] g);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e)
      begin
        n_errors = n_errors + 1;
        $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
    end
  endtask

  task wr(input [7:0] a, input [15:0] d);
    begin
      @(posedge clk);
      wr_stb <= 1'b1;
      addr <= a;
      wr_data <= d;
      @(posedge clk);
      wr_stb <= 1'b0;
    end
  endtask

  task rd(input [7:0] a, output [15:0] d);
    begin
      @(posedge clk);
      rd_stb <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_stb <= 1'b0;
      #1;
      d = rd_data;
    end
  endtask

  task rdc(input [7:0] a, input [15:0] e, input string nm);
    begin
      rd(a, got);
      chk(nm, e, got);
    end
  endtask

  // one-cycle pulse of source bit b of module mm
  task ev(input int mm, input int bb);
    begin
      @(posedge clk);
      case (mm)
        0: transmit_segmenter_evt <= 2'(1 << bb);
        1: if (bb < 5) receive_reassembler_err <= 5'(1 << bb);
           else if (bb == 5) rx_und_evt <= 1'b1;
           else rx_ovr_evt <= 1'b1;
        2: cell_bus_evt <= 3'(1 << bb);
        3: if (bb < 3) serial_bus_evt <= 3'(1 << bb);
           else serial_rund_evt <= 1'b1;
        default: timing_evt <= 7'(1 << bb);
      endcase
      @(posedge clk);
      {transmit_segmenter_evt, receive_reassembler_err, rx_und_evt, rx_ovr_evt} <= '0;
      {cell_bus_evt, serial_bus_evt, serial_rund_evt, timing_evt} <= '0;
    end
  endtask

  task irq_is(input bit e);
    begin
      @(posedge clk);
      #1;
      chk("irq", {15'h0000, e}, {15'h0000, irq});
    end
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task t_reset;
    begin
      rdc(`SIS_A_MSEL, 16'h001F, "msel");
      for (i = 0; i < 24; i = i + 1)
        if (i != 12) rdc(8'(i), 16'h0000, "reset reg");
      rdc(8'h3C, 16'h0000, "unmapped");
      wr(`SIS_A_TX_MK, 16'hFFFF);
      rdc(`SIS_A_TX_MK, 16'h0003, "tx mask");
      wr(`SIS_A_TX_MK, 16'h0000);
      $display("test reset done");
    end
  endtask

  // every source of every module except the rollover bits, summary first then module register
  task t_sources;
    begin
      for (m = 0; m < 5; m = m + 1)
        for (b = 0; b < nb[m]; b = b + 1)
        begin
          ev(m, b);
          rdc(`SIS_A_SUM, 16'(1 << m), "summary");
          rdc(8'(2 + 2 * m), 16'(1 << b), "status");
          chk("irq masked", 16'h0000, {15'h0000, irq});
          wr(8'(2 + 2 * m), 16'(1 << b));
          rdc(`SIS_A_SUM, 16'h0000, "summary clear");
        end
      $display("test sources done");
    end
  endtask

  task t_irq;
    begin
      wr(`SIS_A_RX_MK, 16'h0020);
      ev(1, 5);
      irq_is(1'b1);
      wr(`SIS_A_RX, 16'h0020);
      irq_is(1'b0);
      wr(`SIS_A_RX_MK, 16'h0000);
      wr(`SIS_A_SUM_MK, 16'h0002);
      ev(1, 6);
      irq_is(1'b1);
      wr(`SIS_A_RX, 16'h0040);
      irq_is(1'b0);
      wr(`SIS_A_SUM_MK, 16'h0000);
      // bit 0 of every module through its own mask register
      for (m = 0; m < 5; m = m + 1)
      begin
        wr(8'(3 + 2 * m), 16'h0001);
        ev(m, 0);
        irq_is(1'b1);
        wr(8'(2 + 2 * m), 16'h0001);
        irq_is(1'b0);
        wr(8'(3 + 2 * m), 16'h0000);
      end
      $display("test irq done");
    end
  endtask

  task t_misc;
    begin
      rd(`SIS_A_MCNT, c);
      wr(`SIS_A_MSEL, 16'h0001);
      rx_err_id <= 16'hA5C3;
      ev(1, 1);
      rdc(`SIS_A_MCNT, c, "misc deselected");
      rdc(`SIS_A_MID, 16'h0000, "misc id held");
      @(posedge clk);
      receive_reassembler_err <= 5'h09;
      @(posedge clk);
      receive_reassembler_err <= 5'h00;
      rdc(`SIS_A_MCNT, c + 16'h0001, "misc once");
      rdc(`SIS_A_MID, 16'hA5C3, "misc id");
      wr(`SIS_A_MSEL, 16'h001F);
      wr(`SIS_A_RX, 16'h03FF);
      $display("test misc done");
    end
  endtask

  task t_stats;
    begin
      rd(`SIS_A_UCNT, c);
      rx_und_id <= 16'h1234;
      rx_ovr_id <= 16'h4321;
      serial_rund_slot <= 7'h5A;
      serial_rund_strm <= 4'hC;
      ev(1, 5);
      ev(1, 5);
      rdc(`SIS_A_UCNT, c + 16'h0002, "und count");
      rdc(`SIS_A_UID, 16'h1234, "und id");
      rd(`SIS_A_OCNT, c);
      ev(1, 6);
      rdc(`SIS_A_OCNT, c + 16'h0001, "ovr count");
      rdc(`SIS_A_OID, 16'h4321, "ovr id");
      rd(`SIS_A_TCNT, c);
      ev(3, 3);
      rdc(`SIS_A_TCNT, c + 16'h0001, "rund count");
      rdc(`SIS_A_TPOS, 16'h0C5A, "rund pos");
      rd(`SIS_A_EVCNT, c);
      @(posedge clk);
      timing_ref_evt <= 1'b1;
      repeat (3) @(posedge clk);
      timing_ref_evt <= 1'b0;
      rdc(`SIS_A_EVCNT, c + 16'h0003, "ref count");
      rdc(`SIS_A_TIM, 16'h0000, "no ref roll");
      wr(`SIS_A_RX, 16'h03FF);
      wr(`SIS_A_TDM, 16'h001F);
      rdc(`SIS_A_SUM, 16'h0000, "stats clear");
      @(posedge clk);
      byte_tick <= 1'b1;
      repeat (3) @(posedge clk);
      byte_tick <= 1'b0;
      rdc(`SIS_A_BPLO, 16'h0003, "byte lo");
      rdc(`SIS_A_BPHI, 16'h0000, "byte hi");
      $display("test stats done");
    end
  endtask

  // underrun held long enough to wrap its count; byte tick held 65536
  // cycles so the byte count carries into its high byte
  task t_roll;
    begin
      rd(`SIS_A_UCNT, c);
      @(posedge clk);
      rx_und_evt <= 1'b1;
      byte_tick <= 1'b1;
      repeat (65536 - int'(c)) @(posedge clk);
      rx_und_evt <= 1'b0;
      repeat (int'(c)) @(posedge clk);
      byte_tick <= 1'b0;
      rdc(`SIS_A_UCNT, 16'h0000, "und wrap");
      rdc(`SIS_A_RX, 16'h0120, "und roll flag");
      rdc(`SIS_A_BPLO, 16'h0003, "byte wrap lo");
      rdc(`SIS_A_BPHI, 16'h0001, "byte wrap hi");
      $display("test roll done");
    end
  endtask

  task finish_test;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask

  // clock, and a ceiling well above the roughly 66k cycles of the run
  always #12.5 clk = ~clk;

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      n_errors = n_errors + 1;
      finish_test;
    end
  end

  initial
  begin
    {clk, wr_stb, rd_stb, rx_und_evt, rx_ovr_evt, serial_rund_evt} = '0;
    {timing_ref_evt, byte_tick, addr, wr_data, rx_err_id, rx_und_id} = '0;
    {rx_ovr_id, transmit_segmenter_evt, receive_reassembler_err} = '0;
    {cell_bus_evt, serial_bus_evt, serial_rund_slot, serial_rund_strm} = '0;
    timing_evt = 7'h00;
    reset = 1'b1;
    {n_errors, cmp_count, cyc} = '0;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    t_reset;
    t_sources;
    t_irq;
    t_misc;
    t_stats;
    t_roll;
    finish_test;
  end
endmodule // tb_sar_interrupt_and_statistics

bind sis_top sis_top_chk sis_top_chk_inst (.clk, .reset, .addr, .wr_data, .wr_stb,
  .rd_stb, .rd_data, .transmit_segmenter_evt, .receive_reassembler_err, .rx_err_id,
  .rx_und_evt, .rx_und_id, .rx_ovr_evt, .rx_ovr_id, .cell_bus_evt, .serial_bus_evt,
  .serial_rund_evt, .serial_rund_slot, .serial_rund_strm, .timing_evt,
  .timing_ref_evt, .byte_tick, .irq);
